// ### shared/smc_pkg.sv
// Shared constants, types and states of the static memory pin interface.
package smc_pkg;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_CFG  = 3'h1,
        S_LOOK = 3'h2,
        S_ADDR = 3'h3,
        S_ACC  = 3'h4,
        S_HOLD = 3'h5,
        S_DONE = 3'h6
    } smc_state_t;

    // ------------------------------------------------------------
    // System bus codes
    // ------------------------------------------------------------
    localparam logic [1:0] SMC_TR_ADDR_ONLY = 2'h0;
    localparam logic [1:0] SMC_TR_SEQ = 2'h3;
    localparam logic [1:0] SMC_SZ_BYTE = 2'h0;
    localparam logic [1:0] SMC_SZ_HALF = 2'h1;
    localparam logic [1:0] SMC_SZ_WORD = 2'h2;

    // ------------------------------------------------------------
    // Memory widths and boot straps
    // ------------------------------------------------------------
    localparam logic [1:0] SMC_W32 = 2'h0;
    localparam logic [1:0] SMC_W16 = 2'h1;
    localparam logic [1:0] SMC_W8 = 2'h2;
    localparam logic [1:0] SMC_BOOT_32 = 2'h0;
    localparam logic [1:0] SMC_BOOT_16 = 2'h2;
    localparam logic [1:0] SMC_BOOT_8 = 2'h1;

    // ------------------------------------------------------------
    // Lane masks, steps and configuration storage
    // ------------------------------------------------------------
    localparam logic [3:0] SMC_LANE_BYTE = 4'h1;
    localparam logic [3:0] SMC_LANE_HALF = 4'h3;
    localparam logic [3:0] SMC_LANE_WORD = 4'hF;
    localparam logic [3:0] SMC_WE_IDLE = 4'hF;
    localparam logic [1:0] SMC_DRV_BOTH = 2'h0;
    localparam logic [1:0] SMC_DRV_LOW = 2'h2;
    localparam logic [1:0] SMC_STEP16 = 2'h2;
    localparam logic [1:0] SMC_STEP8 = 2'h1;
    localparam int SMC_CFG_WORDS = 4;
    localparam logic [31:0] SMC_CFG0_RESET = 32'h0000_0004;
    localparam logic [31:0] SMC_CFG_RESET = 32'h0000_0000;
    localparam logic [2:0] SMC_BANK_HI0 = 3'h6;
    localparam logic [2:0] SMC_BANK_ZERO = 3'h0;
    // Bus clocks that write feedback needs to cross both synchronisers.
    localparam logic [3:0] SMC_FB_LAT = 4'h4;

    // One 16-bit bank configuration field.
    typedef struct packed {
        logic       rsv;
        logic       cs_low;
        logic       ready_polarity_select;
        logic       cs_ctl;
        logic       flash_on;
        logic       clk_en;
        logic [1:0] width;
        logic       burst_en;
        logic [2:0] burst_wait;
        logic [3:0] normal_wait;
    } smc_bank_cfg_t;

    // A memory request as captured from the system bus.
    typedef struct packed {
        logic [2:0] bank;
        logic [4:0] addr_lo;
        logic [1:0] size;
        logic [1:0] trans;
        logic       write;
    } smc_req_t;

endpackage

// ### rtl/smc_sync.sv
// Two-flop level synchroniser, parameterised in width and reset value.
module smc_sync
    import smc_pkg::*;
#(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_r <= RST;
            q <= RST;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule

// ### rtl/smc_cfg_mem.sv
// Bank configuration storage with one write port and two registered read ports.
module smc_cfg_mem
    import smc_pkg::*;
#(
    parameter int WORDS = SMC_CFG_WORDS
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic wr_en,
    input wire logic [$clog2(WORDS)-1:0] wr_addr,
    input wire logic [31:0] wr_data,
    input wire logic rd_a_en,
    input wire logic [$clog2(WORDS)-1:0] rd_a_addr,
    output logic [31:0] rd_a_data,
    input wire logic rd_b_en,
    input wire logic [$clog2(WORDS)-1:0] rd_b_addr,
    output logic [31:0] rd_b_data
);

    logic [31:0] mem_r [WORDS];

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < WORDS; i++)
            begin
                mem_r[i] <= (i == 0) ? SMC_CFG0_RESET : SMC_CFG_RESET;
            end
            rd_a_data <= SMC_CFG_RESET;
            rd_b_data <= SMC_CFG_RESET;
        end
        else
        begin
            if (wr_en)
            begin
                mem_r[wr_addr] <= wr_data;
            end
            if (rd_a_en)
            begin
                rd_a_data <= mem_r[rd_a_addr];
            end
            if (rd_b_en)
            begin
                rd_b_data <= mem_r[rd_b_addr];
            end
        end
    end

endmodule

// ### rtl/smc_static_mem.sv
// Static memory controller: system bus slave to external memory pins.
module smc_static_mem
    import smc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic ext_clk,
    input wire logic [2:0] bus_addr_hi,
    input wire logic [4:0] bus_addr_lo,
    input wire logic [31:0] bus_data_i,
    output logic [31:0] bus_data_o,
    output logic bus_data_oe_n,
    input wire logic bus_write,
    input wire logic [1:0] bus_size,
    input wire logic [1:0] bus_trans,
    input wire logic memory_area_select,
    input wire logic config_register_select,
    output logic bus_wait,
    output logic bus_last,
    output logic bus_error,
    output logic bus_resp_oe_n,
    input wire logic expansion_ready,
    input wire logic [3:0] write_enable_feedback_n,
    input wire logic [1:0] boot_mode,
    output logic expansion_clock_out,
    output logic [3:0] byte_write_enable_n,
    output logic external_output_enable_n,
    output logic [5:0] low_bank_select_n,
    output logic [1:0] high_bank_select,
    output logic [1:0] external_addr_low,
    output logic addr_latch_enable_n,
    output logic [1:0] byte_sequence_sel,
    output logic wr_data_latch_n,
    output logic [1:0] wr_lane_drive_n,
    output logic [1:0] rd_data_latch_n,
    output logic rd_bus_drive_n
);

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    // Ready and write feedback are first caught on the link clock, then
    // carried over as levels; the hold state of a write waits out that latency first.
    logic [4:0] link_pins_q;
    logic [4:0] pins_q;
    logic [1:0] strap_q;
    logic rdy_q;
    logic [3:0] wef_q;

    smc_sync #(.W(5), .RST(5'h1F)) u_link_sync (
        .clk(ext_clk),
        .resetn(resetn),
        .d({expansion_ready, write_enable_feedback_n}),
        .q(link_pins_q)
    );

    smc_sync #(.W(5), .RST(5'h1F)) u_core_sync (
        .clk(clk),
        .resetn(resetn),
        .d(link_pins_q),
        .q(pins_q)
    );

    // Straps must move while reset is held, so this one has no reset.
    smc_sync #(.W(2), .RST(SMC_BOOT_32)) u_strap_sync (
        .clk(clk),
        .resetn(1'b1),
        .d(boot_mode),
        .q(strap_q)
    );

    assign rdy_q = pins_q[4];
    assign wef_q = pins_q[3:0];

    // ------------------------------------------------------------
    // State and request registers
    // ------------------------------------------------------------
    smc_state_t st_r;
    smc_state_t st_nxt;
    smc_req_t req_r;
    smc_req_t req_nxt;
    logic [1:0] beat_r;
    logic [1:0] beat_nxt;
    logic [1:0] ea_r;
    logic [1:0] ea_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic [1:0] boot_width_r;
    logic w0_written_r;
    logic rd_w0_r;
    logic clk_gate_r;

    // ------------------------------------------------------------
    // Configuration storage
    // ------------------------------------------------------------
    wire logic cfg_sel_w = config_register_select;
    wire logic mem_sel_w = memory_area_select & ~config_register_select;
    wire logic idle_w = (st_r == S_IDLE);
    wire logic cfg_wr_w = idle_w & cfg_sel_w & bus_write;
    wire logic cfg_rd_w = idle_w & cfg_sel_w & ~bus_write;
    wire logic [1:0] reg_idx_w = bus_addr_lo[3:2];
    logic [31:0] cfg_a_w;
    logic [31:0] cfg_b_w;

    smc_cfg_mem #(.WORDS(SMC_CFG_WORDS)) u_cfg (
        .clk(clk),
        .resetn(resetn),
        .wr_en(cfg_wr_w),
        .wr_addr(reg_idx_w),
        .wr_data(bus_data_i),
        .rd_a_en(cfg_rd_w),
        .rd_a_addr(reg_idx_w),
        .rd_a_data(cfg_a_w),
        .rd_b_en(idle_w),
        .rd_b_addr(bus_addr_hi[2:1]),
        .rd_b_data(cfg_b_w)
    );

    // Until software writes bank zero's word, its width field shows the strap.
    wire logic a_is_w0 = (reg_idx_w == 2'h0);
    wire logic [31:0] rd_word_w = (rd_w0_r && !w0_written_r) ?
        {cfg_a_w[31:10], boot_width_r, cfg_a_w[7:0]} : cfg_a_w;

    wire logic [15:0] half_w = req_r.bank[0] ? cfg_b_w[31:16] : cfg_b_w[15:0];
    wire smc_bank_cfg_t cfg_w = smc_bank_cfg_t'(half_w);
    wire logic [1:0] width_w = (req_r.bank == SMC_BANK_ZERO && !w0_written_r) ?
        boot_width_r : cfg_w.width;

    // ------------------------------------------------------------
    // Access shaping
    // ------------------------------------------------------------
    wire logic w32_w = (width_w == SMC_W32);
    wire logic w16_w = (width_w == SMC_W16);
    wire logic sz_word_w = (req_r.size == SMC_SZ_WORD);
    wire logic sz_half_w = (req_r.size == SMC_SZ_HALF);
    wire logic [1:0] alo_w = req_r.addr_lo[1:0];
    wire logic [1:0] half_base_w = {alo_w[1], 1'b0};

    // Number of external beats minus one.
    wire logic [1:0] last_beat_w = w32_w ? 2'h0 :
        w16_w ? {1'b0, sz_word_w} :
        sz_word_w ? 2'h3 : {1'b0, sz_half_w};

    wire logic [1:0] start_ea_w = (w32_w || sz_word_w) ? 2'h0 :
        (w16_w || sz_half_w) ? half_base_w : alo_w;
    wire logic [1:0] step_w = w16_w ? SMC_STEP16 : SMC_STEP8;

    // Byte lanes asserted by one write beat.
    wire logic [3:0] mask32_w = sz_word_w ? SMC_LANE_WORD :
        sz_half_w ? (SMC_LANE_HALF << half_base_w) : (SMC_LANE_BYTE << alo_w);
    wire logic [3:0] mask16_w = (req_r.size == SMC_SZ_BYTE) ?
        (SMC_LANE_BYTE << alo_w[0]) : SMC_LANE_HALF;
    wire logic [3:0] lanes_w = w32_w ? mask32_w :
        w16_w ? mask16_w : SMC_LANE_BYTE;

    // Sequential reads inside a burst-enabled bank take the short wait.
    wire logic burst_w = cfg_w.burst_en & ~req_r.write &
        (req_r.trans == SMC_TR_SEQ);
    wire logic [3:0] wait_load_w = burst_w ?
        {1'b0, cfg_w.burst_wait} : cfg_w.normal_wait;

    wire logic ready_hold_w = cfg_w.ready_polarity_select ? rdy_q : ~rdy_q;
    wire logic beat_end_w = (st_r == S_ACC) && (cnt_r == 4'h0) && !ready_hold_w;
    wire logic wef_clear_w = &wef_q;
    wire logic last_w = (beat_r == 2'h0);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        req_nxt = req_r;
        beat_nxt = beat_r;
        ea_nxt = ea_r;
        cnt_nxt = cnt_r;
        unique case (st_r)
            S_IDLE:
            begin
                if (cfg_sel_w && !bus_write)
                begin
                    st_nxt = S_CFG;
                end
                else if (mem_sel_w && bus_trans != SMC_TR_ADDR_ONLY)
                begin
                    st_nxt = S_LOOK;
                    req_nxt = '{bank: bus_addr_hi, addr_lo: bus_addr_lo,
                        size: bus_size, trans: bus_trans, write: bus_write};
                end
            end
            S_CFG:
            begin
                st_nxt = S_IDLE;
            end
            S_LOOK:
            begin
                st_nxt = S_ADDR;
                beat_nxt = last_beat_w;
                ea_nxt = start_ea_w;
            end
            S_ADDR:
            begin
                st_nxt = S_ACC;
                cnt_nxt = wait_load_w;
            end
            S_ACC:
            begin
                if (cnt_r != 4'h0)
                begin
                    cnt_nxt = cnt_r - 4'h1;
                end
                else if (beat_end_w)
                begin
                    st_nxt = S_HOLD;
                    cnt_nxt = req_r.write ? SMC_FB_LAT : 4'h0;
                end
            end
            S_HOLD:
            begin
                if (cnt_r != 4'h0)
                begin
                    cnt_nxt = cnt_r - 4'h1;
                end
                else if (wef_clear_w)
                begin
                    if (last_w)
                    begin
                        st_nxt = S_DONE;
                    end
                    else
                    begin
                        st_nxt = S_ADDR;
                        beat_nxt = beat_r - 2'h1;
                        ea_nxt = ea_r + step_w;
                    end
                end
            end
            S_DONE:
            begin
                st_nxt = S_IDLE;
            end
            default:
            begin
                st_nxt = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_r <= S_IDLE;
            req_r <= '0;
            beat_r <= 2'h0;
            ea_r <= 2'h0;
            cnt_r <= 4'h0;
            w0_written_r <= 1'b0;
            rd_w0_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            req_r <= req_nxt;
            beat_r <= beat_nxt;
            ea_r <= ea_nxt;
            cnt_r <= cnt_nxt;
            w0_written_r <= w0_written_r | (cfg_wr_w & a_is_w0);
            rd_w0_r <= cfg_rd_w ? a_is_w0 : rd_w0_r;
        end
    end

    // The strap is followed throughout reset and frozen on release.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            boot_width_r <= (strap_q == SMC_BOOT_16) ? SMC_W16 :
                (strap_q == SMC_BOOT_8) ? SMC_W8 : SMC_W32;
        end
    end

    // ------------------------------------------------------------
    // System bus responses
    // ------------------------------------------------------------
    wire logic sel_w = memory_area_select | config_register_select;
    wire logic done_w = (st_r == S_DONE) || (st_r == S_CFG) || cfg_wr_w ||
        (idle_w && mem_sel_w && bus_trans == SMC_TR_ADDR_ONLY);

    assign bus_wait = sel_w & ~done_w;
    assign bus_last = 1'b0;
    assign bus_error = 1'b0;
    assign bus_resp_oe_n = ~sel_w;
    assign bus_data_o = rd_word_w;
    assign bus_data_oe_n = ~(st_r == S_CFG);

    // ------------------------------------------------------------
    // External pins
    // ------------------------------------------------------------
    wire logic ext_act_w = (st_r == S_ADDR) || (st_r == S_ACC) || (st_r == S_HOLD);
    wire logic [7:0] cs_act_w = ext_act_w ? (8'h01 << req_r.bank) : 8'h00;

    assign low_bank_select_n = ~cs_act_w[5:0];
    assign high_bank_select = cs_act_w[7:6];
    assign external_addr_low = ea_r;
    assign byte_sequence_sel = ea_r;
    assign addr_latch_enable_n = ~(st_r == S_ADDR);
    assign byte_write_enable_n = (st_r == S_ACC && req_r.write) ?
        ~lanes_w : SMC_WE_IDLE;
    assign external_output_enable_n = ~(st_r == S_ACC && !req_r.write);
    assign wr_data_latch_n = ~(st_r == S_LOOK && req_r.write);
    assign wr_lane_drive_n = (ext_act_w && req_r.write) ?
        (w32_w ? SMC_DRV_BOTH : SMC_DRV_LOW) : ~SMC_DRV_BOTH;
    assign rd_data_latch_n = (beat_end_w && !req_r.write) ?
        (w32_w ? SMC_DRV_BOTH : ~(2'h1 << ea_r[1])) : ~SMC_DRV_BOTH;
    assign rd_bus_drive_n = ~(st_r == S_DONE && !req_r.write);

    // The gate changes on the falling edge so the clock never chops a pulse.
    always_ff @(negedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            clk_gate_r <= 1'b0;
        end
        else
        begin
            clk_gate_r <= ext_act_w & cfg_w.clk_en;
        end
    end

    assign expansion_clock_out = clk & clk_gate_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    bus_drive_only_a: assert property (@(posedge clk) disable iff (!resetn)
        !bus_data_oe_n |-> (st_r == S_CFG) && $past(cfg_rd_w))
        else $error("system data driven outside a register read");

    resp_low_a: assert property (@(posedge clk) disable iff (!resetn)
        sel_w |-> !bus_error && !bus_last)
        else $error("error or last response high while selected");

    wait_busy_a: assert property (@(posedge clk) disable iff (!resetn)
        (sel_w && (st_r == S_LOOK || st_r == S_ADDR || st_r == S_ACC)) |-> bus_wait)
        else $error("wait low during an unfinished transfer");

    ready_extend_a: assert property (@(posedge clk) disable iff (!resetn)
        (st_r == S_ACC && cnt_r == 4'h0 && ready_hold_w) |=> (st_r == S_ACC))
        else $error("transfer ended while ready held it");

    we_idle_a: assert property (@(posedge clk) disable iff (!resetn)
        (st_r != S_ACC || !req_r.write) |-> (byte_write_enable_n == SMC_WE_IDLE))
        else $error("write enable low outside a write transfer");

    hold_stable_a: assert property (@(posedge clk) disable iff (!resetn)
        (st_r == S_HOLD && !wef_clear_w) |=> $stable(external_addr_low)
            && $stable(low_bank_select_n) && (st_r == S_HOLD))
        else $error("address or select moved during write hold");

    latch_idle_a: assert property (@(posedge clk) disable iff (!resetn)
        (st_r != S_ADDR) |-> addr_latch_enable_n)
        else $error("address latch open with no new address");

    cs_onehot_a: assert property (@(posedge clk) disable iff (!resetn)
        ext_act_w |-> $onehot(cs_act_w) && cs_act_w[req_r.bank])
        else $error("chip select does not match the bank");

    oe_read_a: assert property (@(posedge clk) disable iff (!resetn)
        (st_r == S_ADDR && !req_r.write) |=> !external_output_enable_n)
        else $error("output enable not low during a read access");

    wait_count_a: assert property (@(posedge clk) disable iff (!resetn)
        (st_r == S_ADDR && wait_load_w == 4'h0) |=> (st_r == S_ACC) && (cnt_r == 4'h0)
            ##1 ((st_r != S_ACC) || $past(ready_hold_w)))
        else $error("zero wait load gave a longer access");

endmodule

// ### testbench/smc_ext_mem_model.sv
// External memory side: ready source and write enable pad feedback.
module smc_ext_mem_model
(
    input wire logic ext_clk,
    input wire logic resetn,
    input wire logic stall,
    input wire logic [3:0] byte_write_enable_n,
    output logic expansion_ready,
    output logic [3:0] write_enable_feedback_n
);
    timeunit 1ns;
    timeprecision 100ps;
    // Feedback lags the enables by a link clock, so hold must really wait for it.
    always_ff @(posedge ext_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            write_enable_feedback_n <= 4'hF;
            expansion_ready <= 1'b1;
        end
        else
        begin
            write_enable_feedback_n <= byte_write_enable_n;
            expansion_ready <= !stall;
        end
    end
endmodule

// ### testbench/tb_smc_static_mem.sv
// Self-checking bench for the static memory pin interface.
module tb_smc_static_mem
    import smc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {logic w; logic [2:0] b; logic [1:0] s; logic [4:0] a; logic [3:0] l;}
        smc_row_t;
    logic clk = 0, resetn = 0, ext_clk = 0, stall = 0, bus_write = 0, memory_area_select = 0;
    logic config_register_select = 0, bus_data_oe_n, bus_wait, bus_last, bus_error, oes, bad;
    logic bus_resp_oe_n, expansion_ready, expansion_clock_out, external_output_enable_n;
    logic addr_latch_enable_n, wr_data_latch_n, rd_bus_drive_n, rdd, wdl;
    logic [1:0] bus_size = '0, bus_trans = '0, boot_mode = '0, high_bank_select, csh, eas;
    logic [1:0] bss, wld, rdl, tr = 2'h2;
    logic [1:0] external_addr_low, byte_sequence_sel, wr_lane_drive_n, rd_data_latch_n;
    logic [2:0] bus_addr_hi = '0;
    logic [4:0] bus_addr_lo = '0;
    logic [31:0] bus_data_i = '0, bus_data_o, rd;
    logic [3:0] byte_write_enable_n, write_enable_feedback_n, lanes;
    logic [5:0] low_bank_select_n, csl;
    int num_errors = 0, check_count = 0, ck_n = 0, n = 0, ales = 0;
    smc_row_t r;
    localparam smc_row_t ROWS [10] = '{
        '{1'h1, 3'h0, 2'h2, 5'h00, 4'hF}, '{1'h1, 3'h1, 2'h1, 5'h02, 4'hC},
        '{1'h1, 3'h2, 2'h1, 5'h00, 4'h3}, '{1'h1, 3'h3, 2'h0, 5'h00, 4'h1},
        '{1'h1, 3'h4, 2'h0, 5'h01, 4'h2}, '{1'h1, 3'h5, 2'h0, 5'h02, 4'h4},
        '{1'h1, 3'h6, 2'h0, 5'h03, 4'h8}, '{1'h1, 3'h7, 2'h1, 5'h01, 4'h3},
        '{1'h0, 3'h7, 2'h2, 5'h00, 4'h0}, '{1'h0, 3'h0, 2'h0, 5'h01, 4'h0}};

    smc_static_mem smc_static_mem_i (.*);
    smc_ext_mem_model smc_ext_mem_model_i (.ext_clk(ext_clk), .resetn(resetn), .stall(stall),
        .byte_write_enable_n(byte_write_enable_n), .expansion_ready(expansion_ready),
        .write_enable_feedback_n(write_enable_feedback_n));

    always #5 clk = ~clk;
    always @(posedge expansion_clock_out) ck_n++;
    initial
    begin
        #1.7;
        forever #3 ext_clk = ~ext_clk;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic do_reset(input logic [1:0] m);
        resetn = 0;
        boot_mode = m;
        repeat (5) @(negedge clk);
        resetn = 1;
        @(negedge clk);
    endtask

    task automatic reg_acc(input logic w, input logic [1:0] i, input logic [31:0] d);
        {bus_write, bus_addr_lo, bus_data_i, config_register_select} = {w, 1'b0, i, 2'h0, d, 1'b1};
        @(negedge clk);
        rd = bus_data_o;
        oes = bus_data_oe_n;
        // A read is answered a cycle later, so its select stands through that edge.
        if (!w)
        begin
            chk("cfg_wait", 0, bus_wait);
            @(negedge clk);
        end
        config_register_select = 0;
        @(negedge clk);
    endtask

    // Holds the request until the wait response drops, gathering what the pins showed.
    task automatic mem(input logic w, input logic [2:0] b, input logic [1:0] s, input logic [4:0] a);
        {bus_write, bus_addr_hi, bus_size, bus_addr_lo, bus_trans} = {w, b, s, a, tr};
        memory_area_select = 1;
        {lanes, csh, eas, oes, bad, n, ck_n, csl} = {10'h000, 64'h0, 6'h3F};
        {bss, wld, rdl, rdd, wdl, ales} = {2'h0, 4'hF, 2'h0, 32'h0};
        do
        begin
            @(negedge clk);
            n++;
            lanes |= ~byte_write_enable_n;
            csl &= low_bank_select_n;
            csh |= high_bank_select;
            eas |= external_addr_low;
            bss |= byte_sequence_sel;
            wld &= wr_lane_drive_n;
            rdl &= rd_data_latch_n;
            rdd |= ~rd_bus_drive_n;
            wdl |= ~wr_data_latch_n;
            ales += !addr_latch_enable_n;
            oes |= ~external_output_enable_n;
            bad |= bus_last | bus_error | bus_resp_oe_n | ~bus_data_oe_n;
        end
        while (bus_wait && n < 400);
        chk("wait_end", 0, bus_wait);
        // The released wait is taken at the next rising edge, so the select stands past it.
        @(negedge clk);
        memory_area_select = 0;
        @(negedge clk);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        do_reset(SMC_BOOT_32);
        foreach (ROWS[k])
        begin
            r = ROWS[k];
            mem(r.w, r.b, r.s, r.a);
            chk("lanes", r.l, lanes);
            chk("cs_low", r.b < 6 ? 6'(~(6'h01 << r.b)) : 6'h3F, csl);
            chk("cs_high", r.b > 5 ? 2'h1 << (r.b - 6) : 2'h0, csh);
            chk("oe", !r.w, oes);
            chk("resp", '0, {bad, ck_n != 0});
            chk("ale", 1, ales);
            chk("paths", r.w ? 4'h3 : 4'hC, {wld, rdl});
            chk("drive", {r.w, !r.w}, {wdl, rdd});
        end
        reg_acc(0, 2'h0, '0);
        chk("cfg0", 32'h0000_0004, rd);
        chk("data_oe", 0, oes);
        reg_acc(1, 2'h1, 32'h0000_0400);
        reg_acc(0, 2'h1, '0);
        chk("cfg1", 32'h0000_0400, rd);
        mem(0, 3'h2, SMC_SZ_WORD, 5'h00);
        chk("clock_run", 1, ck_n != 0);
        {bus_trans, bus_addr_hi, memory_area_select} = {SMC_TR_ADDR_ONLY, 3'h3, 1'b1};
        @(negedge clk);
        chk("addr_only", {1'b0, 6'h3F}, {bus_wait, low_bank_select_n});
        memory_area_select = 0;
        @(negedge clk);
        mem(0, 3'h1, SMC_SZ_WORD, 5'h00);
        chk("beats", 5, n);
        stall = 1;
        repeat (8) @(negedge clk);
        fork
            #200 stall = 0;
        join_none
        mem(0, 3'h1, SMC_SZ_WORD, 5'h00);
        chk("ready_hold", 1, n > 20);
        reg_acc(1, 2'h0, 32'h2000_0004);
        stall = 1;
        repeat (8) @(negedge clk);
        mem(0, 3'h1, SMC_SZ_WORD, 5'h00);
        chk("ready_inv", 5, n);
        stall = 0;
        reg_acc(1, 2'h2, 32'h0000_0083);
        tr = SMC_TR_SEQ;
        mem(0, 3'h4, SMC_SZ_WORD, 5'h00);
        chk("burst", 5, n);
        tr = 2'h2;
        mem(0, 3'h4, SMC_SZ_WORD, 5'h00);
        chk("normal", 8, n);
        for (int j = 0; j < 2; j++)
        begin
            do_reset(j ? SMC_BOOT_8 : SMC_BOOT_16);
            reg_acc(0, 2'h0, '0);
            chk("strap", j ? 32'h0000_0204 : 32'h0000_0104, rd);
            mem(1, 3'h0, SMC_SZ_WORD, 5'h00);
            chk("beat_addr", j ? 4'hF : 4'hA, {eas, bss});
            chk("beat_ale", j ? 4 : 2, ales);
            chk("narrow", 4'hB, {wld, rdl});
        end
        conclude();
    end

    initial
    begin
        #100000;
        num_errors++;
        conclude();
    end
endmodule
